// file: mdacwp_top.sv
// Host write port of a multichannel current-output converter board
`timescale 1ns/10ps
`default_nettype none
module mdacwp_top #(
	parameter int CHANNELS = mdacwp_pkg::CHANNELS_FULL
) (
	input  wire logic                                        CLOCK,
	input  wire logic                                        RESET,
	input  wire logic                                        CLOCK_ENABLE,
	input  wire logic [mdacwp_pkg::SWITCH_W-1:0]             BASE_SWITCHES,
	input  wire logic [mdacwp_pkg::ADDR_W-1:0]               IO_ADDR,
	input  wire logic [mdacwp_pkg::BYTE_W-1:0]               IO_WDATA,
	input  wire logic                                        IO_WRITE,
	output var  logic [CHANNELS-1:0][mdacwp_pkg::CODE_W-1:0] CHANNEL_CODE,
	output var  logic [CHANNELS-1:0]                         CHANNEL_UPDATED
);
	// Top code bits carried by the second write
	localparam int NIBBLE_W = 4;

	// Only the two documented build sizes are served
	if (CHANNELS != mdacwp_pkg::CHANNELS_FULL && CHANNELS != mdacwp_pkg::CHANNELS_HALF) begin : g_bad_size
		$error("CHANNELS must be 8 or 16");
	end

	// Channel field must be able to name every fitted channel
	if (CHANNELS > (1 << mdacwp_pkg::CHAN_W)) begin : g_bad_chan_w
		$error("Channel field too narrow for CHANNELS");
	end

	// Switches cover every address bit above the offset bit
	if (mdacwp_pkg::SWITCH_W != mdacwp_pkg::ADDR_W - 1) begin : g_bad_switch_w
		$error("SWITCH_W must be ADDR_W - 1");
	end

	// Host data path is one byte wide
	if (mdacwp_pkg::BYTE_W != 8) begin : g_bad_byte_w
		$error("BYTE_W must be 8");
	end

	// Code is one staged byte plus one nibble from the second write
	if (mdacwp_pkg::CODE_W != mdacwp_pkg::BYTE_W + NIBBLE_W) begin : g_bad_code_w
		$error("CODE_W must be BYTE_W plus one nibble");
	end

	// Nibble and channel field must not overlap
	if (mdacwp_pkg::CODE_MSB_POS + NIBBLE_W > mdacwp_pkg::CHAN_FIELD_POS) begin : g_bad_nibble_pos
		$error("Code nibble overlaps the channel field");
	end

	// Channel field must stay inside the data byte
	if (mdacwp_pkg::CHAN_FIELD_POS + mdacwp_pkg::CHAN_W > mdacwp_pkg::BYTE_W) begin : g_bad_chan_pos
		$error("Channel field runs past the data byte");
	end

	// The two registers must sit at distinct offsets
	if (mdacwp_pkg::OFS_CODE_LOW == mdacwp_pkg::OFS_CODE_HIGH) begin : g_bad_offsets
		$error("Register offsets must differ");
	end

	// Whole decode-side state of the port in one record; the latch bank keeps its own
	typedef struct packed {
		// Two-stage switch synchroniser; switches are not on this clock
		logic [mdacwp_pkg::SWITCH_W-1:0] sw_meta;
		logic [mdacwp_pkg::SWITCH_W-1:0] sw_sync;
		// Staged low byte, kept across updates
		logic [mdacwp_pkg::BYTE_W-1:0]   low;
		// One-cycle load request towards the latch bank
		logic                            load;
		logic [mdacwp_pkg::CHAN_W-1:0]   chan;
		logic [mdacwp_pkg::CODE_W-1:0]   code;
	} mdacwp_port_s;

	mdacwp_port_s st_q;
	mdacwp_port_s st_d;

	// Carrier between decode and latch bank
	mdacwp_load_if load_bus ();

	// Address match against the switch-selected base plus a one-bit offset
	function automatic logic addr_hit(
		input logic [mdacwp_pkg::ADDR_W-1:0]   addr,
		input logic [mdacwp_pkg::SWITCH_W-1:0] base,
		input logic                            ofs
	);
		addr_hit = (addr[mdacwp_pkg::ADDR_W-1:1] == base) && (addr[0] == ofs);
	endfunction : addr_hit

	// Channel number from the second register's upper field
	function automatic logic [mdacwp_pkg::CHAN_W-1:0] chan_of(
		input logic [mdacwp_pkg::BYTE_W-1:0] data
	);
		chan_of = data[mdacwp_pkg::CHAN_FIELD_POS +: mdacwp_pkg::CHAN_W];
	endfunction : chan_of

	// Top code bits from the second register's lower field
	function automatic logic [NIBBLE_W-1:0] nibble_of(
		input logic [mdacwp_pkg::BYTE_W-1:0] data
	);
		nibble_of = data[mdacwp_pkg::CODE_MSB_POS +: NIBBLE_W];
	endfunction : nibble_of

	// Full code: new top nibble above the staged low byte
	function automatic logic [mdacwp_pkg::CODE_W-1:0] join_code(
		input logic [NIBBLE_W-1:0]           top,
		input logic [mdacwp_pkg::BYTE_W-1:0] low
	);
		join_code = {top, low};
	endfunction : join_code

	// Decoded strobes for the two registers
	logic                          hit_low;
	logic                          hit_high;

	// Fields of the second register
	logic [mdacwp_pkg::CHAN_W-1:0] wr_chan;
	logic [NIBBLE_W-1:0]           wr_nibble;

	// Decode uses only the synchronised switches; the first stage feeds nothing else
	assign hit_low   = IO_WRITE && addr_hit(IO_ADDR, st_q.sw_sync, mdacwp_pkg::OFS_CODE_LOW);
	assign hit_high  = IO_WRITE && addr_hit(IO_ADDR, st_q.sw_sync, mdacwp_pkg::OFS_CODE_HIGH);

	// Field split of the second register
	assign wr_chan   = chan_of(IO_WDATA);
	assign wr_nibble = nibble_of(IO_WDATA);

	// Next state: staging byte, switch sync, one-cycle load request
	always_comb begin
		st_d         = st_q;

		// Switch pipeline runs every enabled cycle
		st_d.sw_meta = BASE_SWITCHES;
		st_d.sw_sync = st_q.sw_meta;

		// Request lasts exactly one enabled cycle
		st_d.load    = 1'b0;

		// Staging only; outputs stay put until the high write arrives
		if (hit_low) begin
			st_d.low = IO_WDATA;
		end

		// Staged byte is left untouched here so it may be reused
		if (hit_high) begin
			st_d.load = 1'b1;
			st_d.chan = wr_chan;
			st_d.code = join_code(wr_nibble, st_q.low);
		end
	end

	// Freeze everything while the clock enable is low
	// A write shows on the outputs two enabled edges after its strobe
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			st_q.sw_meta <= mdacwp_pkg::SWITCH_RESET;
			st_q.sw_sync <= mdacwp_pkg::SWITCH_RESET;
			st_q.low     <= mdacwp_pkg::LOW_RESET;
			st_q.load    <= 1'b0;
			st_q.chan    <= '0;
			st_q.code    <= mdacwp_pkg::CODE_RESET;
		end else if (CLOCK_ENABLE) begin
			st_q <= st_d;
		end
	end

	// The load request with its channel and code goes to the latch bank over load_bus
	assign load_bus.load = st_q.load;
	assign load_bus.chan = st_q.chan;
	assign load_bus.code = st_q.code;

	// Latch bank owns every output flip-flop
	mdacwp_chan_bank #(
		.CHANNELS (CHANNELS)
	) u_bank (
		.clock   (CLOCK),
		.reset   (RESET),
		.enable  (CLOCK_ENABLE),
		.req     (load_bus),
		.codes   (CHANNEL_CODE),
		.updated (CHANNEL_UPDATED)
	);
endmodule : mdacwp_top
`default_nettype wire

// file: mdacwp_pkg.sv
// Constants shared by the channel write port and its channel latch bank
package mdacwp_pkg;
	localparam int       CODE_W          = 12;     // Converter code width
	localparam int       BYTE_W          = 8;      // Host data bus width
	localparam int       CHAN_W          = 4;      // Channel field width
	localparam int       ADDR_W          = 10;     // Host I/O address width
	localparam int       SWITCH_W        = 9;      // Base switches select address bits 9..1
	localparam int       CHANNELS_FULL   = 16;     // Larger build
	localparam int       CHANNELS_HALF   = 8;      // Smaller build
	localparam logic     OFS_CODE_LOW    = 1'h0;   // code_low_byte offset
	localparam logic     OFS_CODE_HIGH   = 1'h1;   // code_high_nibble_and_channel offset
	localparam int       CODE_MSB_POS    = 0;      // Top code nibble sits at bits 3..0
	localparam int       CHAN_FIELD_POS  = 4;      // channel_select_field at bits 7..4
	localparam logic [11:0] CODE_RESET   = 12'h000;
	localparam logic [7:0]  LOW_RESET    = 8'h00;
	localparam logic [8:0]  SWITCH_RESET = 9'h000;
endpackage : mdacwp_pkg

// file: mdacwp_load_if.sv
// Load request carried from the register decode to the channel latch bank
`timescale 1ns/10ps
`default_nettype none
interface mdacwp_load_if;
	logic        load;
	logic [3:0]  chan;
	logic [11:0] code;
	modport issuer (output load, output chan, output code);
	modport bank   (input load, input chan, input code);
endinterface : mdacwp_load_if
`default_nettype wire

// file: mdacwp_chan_bank.sv
// Per-channel converter code latches with one-cycle update pulses
`timescale 1ns/10ps
`default_nettype none
module mdacwp_chan_bank #(
	parameter int CHANNELS = mdacwp_pkg::CHANNELS_FULL
) (
	input  wire logic                                    clock,
	input  wire logic                                    reset,
	input  wire logic                                    enable,
	mdacwp_load_if.bank                                  req,
	output var  logic [CHANNELS-1:0][mdacwp_pkg::CODE_W-1:0] codes,
	output var  logic [CHANNELS-1:0]                     updated
);
	typedef struct packed {
		logic [CHANNELS-1:0][mdacwp_pkg::CODE_W-1:0] code;
		logic [CHANNELS-1:0]                         upd;
	} mdacwp_bank_s;

	mdacwp_bank_s st_q;
	mdacwp_bank_s st_d;

	// Plain binary channel index; unfitted channels match nothing and are dropped
	always_comb begin
		st_d     = st_q;
		st_d.upd = '0;
		for (int i = 0; i < CHANNELS; i++) begin
			if (req.load && (req.chan == i[3:0])) begin
				st_d.code[i] = req.code;
				st_d.upd[i]  = 1'b1;
			end
		end
	end

	// Latches are cleared only so outputs are known; software must still load each one
	always_ff @(posedge clock) begin
		if (reset) begin
			st_q.code <= {CHANNELS{mdacwp_pkg::CODE_RESET}};
			st_q.upd  <= '0;
		end else if (enable) begin
			st_q <= st_d;
		end
	end

	assign codes   = st_q.code;
	assign updated = st_q.upd;
endmodule : mdacwp_chan_bank
`default_nettype wire

// file: mdacwp_asserts.sv
// Port checks for the converter write port
`timescale 1ns/10ps
`default_nettype none
module mdacwp_asserts #(parameter int CHANNELS = 16) (
	input wire logic                      CLOCK,
	input wire logic                      RESET,
	input wire logic                      CLOCK_ENABLE,
	input wire logic [8:0]                BASE_SWITCHES,
	input wire logic [9:0]                IO_ADDR,
	input wire logic [7:0]                IO_WDATA,
	input wire logic                      IO_WRITE,
	input wire logic [CHANNELS-1:0][11:0] CHANNEL_CODE,
	input wire logic [CHANNELS-1:0]       CHANNEL_UPDATED
);
	logic       hi;
	logic       lo;
	logic [7:0] lo_q;
	// Window decode; switches are held still by the bench
	assign hi = IO_WRITE && CLOCK_ENABLE && IO_ADDR == {BASE_SWITCHES, 1'h1};
	assign lo = IO_WRITE && CLOCK_ENABLE && IO_ADDR == {BASE_SWITCHES, 1'h0};
	// Shadow of the staged low byte
	always_ff @(posedge CLOCK) lo_q <= RESET ? 8'h00 : lo ? IO_WDATA : lo_q;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);
	sequence s_load; hi && IO_WDATA[7:4] < CHANNELS ##1 CLOCK_ENABLE; endsequence
	sequence s_drop; hi && IO_WDATA[7:4] >= CHANNELS ##1 CLOCK_ENABLE; endsequence
	property p_code;
		s_load |=> CHANNEL_CODE[$past(IO_WDATA[7:4], 2)] == {$past(IO_WDATA[3:0], 2), $past(lo_q, 2)};
	endproperty
	property p_pulse; s_load |=> CHANNEL_UPDATED == (CHANNELS'(1) << $past(IO_WDATA[7:4], 2)); endproperty
	property p_drop; s_drop |=> CHANNEL_UPDATED == '0 && $stable(CHANNEL_CODE); endproperty
	property p_cause;
		CHANNEL_UPDATED != '0 && $past(CLOCK_ENABLE) && $past(CLOCK_ENABLE, 2) |-> $past(hi, 2);
	endproperty
	property p_still; CHANNEL_UPDATED == '0 |-> $stable(CHANNEL_CODE); endproperty
	property p_onehot; $onehot0(CHANNEL_UPDATED); endproperty
	property p_freeze; !CLOCK_ENABLE |=> $stable(CHANNEL_CODE) && $stable(CHANNEL_UPDATED); endproperty
	property p_one; CHANNEL_UPDATED != '0 && CLOCK_ENABLE ##1 !$past(hi, 2) |-> CHANNEL_UPDATED == '0; endproperty
	a_code: assert property (p_code) else $error("loaded code wrong");
	a_pulse: assert property (p_pulse) else $error("wrong channel pulsed");
	a_drop: assert property (p_drop) else $error("unfitted channel write acted");
	a_cause: assert property (p_cause) else $error("pulse without high write");
	a_still: assert property (p_still) else $error("code moved without pulse");
	a_onehot: assert property (p_onehot) else $error("several channels pulsed");
	a_freeze: assert property (p_freeze) else $error("moved while disabled");
	a_one: assert property (p_one) else $error("pulse too long");
endmodule : mdacwp_asserts
`default_nettype wire

// file: mdacwp_host.sv
// Host bus master issuing byte writes
`timescale 1ns/10ps
`default_nettype none
module mdacwp_host #(parameter logic [9:0] BASE = 10'h300) (
	input  wire logic       clock,
	output var  logic [9:0] addr,
	output var  logic [7:0] wdata,
	output var  logic       write
);
	initial begin
		addr = 10'h000;
		wdata = 8'h00;
		write = 1'b0;
	end
	// One-cycle strobe; data inverted after so a stale byte never looks held
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge clock);
		addr <= a;
		wdata <= d;
		write <= 1'b1;
		@(negedge clock);
		write <= 1'b0;
		wdata <= ~d;
	endtask : wr
	// Full update, low byte first
	task automatic put(input logic [3:0] ch, input logic [11:0] c);
		wr(BASE, c[7:0]);
		wr(BASE + 10'h001, {ch, c[11:8]});
	endtask : put
endmodule : mdacwp_host
`default_nettype wire

// file: mdacwp_top_test.sv
// Self-checking bench for the converter write port
`timescale 1ns/10ps
`default_nettype none
module mdacwp_top_test;
	localparam int N = 8;
	localparam logic [9:0] BASE = 10'h300;
	logic             CLOCK = 1'b0;
	logic             RESET = 1'b1;
	logic             CLOCK_ENABLE = 1'b1;
	logic [9:0]       IO_ADDR;
	logic [7:0]       IO_WDATA;
	logic             IO_WRITE;
	logic [N-1:0][11:0] CHANNEL_CODE;
	logic [N-1:0]       CHANNEL_UPDATED;
	logic [N-1:0][11:0] exp = '0;
	int               err_count = 0;
	int               checks_done = 0;
	// 20 MHz clock
	always #25 CLOCK = ~CLOCK;
	mdacwp_host #(.BASE(BASE)) host (.clock(CLOCK), .addr(IO_ADDR), .wdata(IO_WDATA), .write(IO_WRITE));
	mdacwp_top #(.CHANNELS(N)) uut (.CLOCK(CLOCK), .RESET(RESET), .CLOCK_ENABLE(CLOCK_ENABLE),
		.BASE_SWITCHES(BASE[9:1]), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_WRITE(IO_WRITE),
		.CHANNEL_CODE(CHANNEL_CODE), .CHANNEL_UPDATED(CHANNEL_UPDATED));
	task automatic cmp_upd(input string what, input logic [N-1:0] e, input logic [N-1:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_upd
	task automatic cmp(input string what, input logic [N*12-1:0] e, input logic [N*12-1:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : cmp
	// Load lands two cycles after the strobe
	task automatic settle;
		repeat (2) @(negedge CLOCK);
	endtask : settle
	task automatic t_walk;
		host.put(4'h3, 12'h7E4);
		exp[3] = 12'h7E4;
		@(negedge CLOCK);
		cmp_upd("pulse", 8'h08, CHANNEL_UPDATED);
		cmp("walk", exp, CHANNEL_CODE);
		@(negedge CLOCK);
		cmp_upd("pulse end", 8'h00, CHANNEL_UPDATED);
		$display("walk done");
	endtask : t_walk
	task automatic t_stage;
		host.wr(BASE, 8'hFF);
		settle();
		cmp("staged", exp, CHANNEL_CODE);
		host.wr(BASE + 10'h001, 8'h5F);
		host.put(4'h7, 12'h001);
		exp[5] = 12'hFFF;
		exp[7] = 12'h001;
		settle();
		cmp("reuse", exp, CHANNEL_CODE);
		host.wr(BASE + 10'h001, 8'h22);
		exp[2] = 12'h201;
		settle();
		cmp("kept low", exp, CHANNEL_CODE);
		$display("stage done");
	endtask : t_stage
	task automatic t_refuse;
		host.wr(BASE + 10'h001, 8'h9A);
		host.wr(BASE + 10'h003, 8'h21);
		CLOCK_ENABLE <= 1'b0;
		host.wr(BASE + 10'h001, 8'h41);
		CLOCK_ENABLE <= 1'b1;
		settle();
		cmp("refused", exp, CHANNEL_CODE);
		$display("refuse done");
	endtask : t_refuse
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : final_report
	// Tests need about 43 cycles
	initial begin
		#50000;
		err_count++;
		final_report();
	end
	initial begin
		repeat (10) @(negedge CLOCK);
		RESET = 1'b0;
		repeat (3) @(negedge CLOCK);
		cmp("reset", exp, CHANNEL_CODE);
		t_walk();
		t_stage();
		t_refuse();
		final_report();
	end
endmodule : mdacwp_top_test
bind mdacwp_top mdacwp_asserts #(.CHANNELS(CHANNELS)) chk (.*);
`default_nettype wire
